// [shared/hbs_pkg.sv]
/*
  hbs_pkg: constants, register map and types of the holding brake
  sequencer.
  assumes a 100 MHz mclk and a 32-bit Avalon-MM master on the bus.
*/
package hbs_pkg;

  // ====================================================
  // timing
  localparam int CLK_NS = 10;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  localparam int DIV_W = $clog2(TICK_CYC);
  localparam int TW = 20;
  localparam int SW = 16;
  localparam real MAG_TIME_S = 0.0;
  localparam real OPEN_TIME_S = 0.1;
  localparam real CLOSE_TIME_S = 0.1;
  localparam real MON_TIME_S = 300.0;
  localparam real PCD_TIME_S = 0.01;
  localparam int STANDSTILL_RPM = 20;

  // ====================================================
  // reset values (timers in 1 ms ticks)
  localparam logic [TW-1:0] RST_MAG = TW'(int'(MAG_TIME_S * 1000.0));
  localparam logic [TW-1:0] RST_OPEN = TW'(int'(OPEN_TIME_S * 1000.0));
  localparam logic [TW-1:0] RST_CLOSE = TW'(int'(CLOSE_TIME_S * 1000.0));
  localparam logic [TW-1:0] RST_MON = TW'(int'(MON_TIME_S * 1000.0));
  localparam logic [TW-1:0] RST_PCD = TW'(int'(PCD_TIME_S * 1000.0));
  localparam logic [SW-1:0] RST_THR = SW'(STANDSTILL_RPM);
  localparam logic [11:0] RST_MODE = 12'h000;

  // ====================================================
  // register byte addresses
  localparam logic [7:0] ADR_CMD = 8'h00;
  localparam logic [7:0] ADR_MODE = 8'h04;
  localparam logic [7:0] ADR_MAG = 8'h08;
  localparam logic [7:0] ADR_OPEN = 8'h0C;
  localparam logic [7:0] ADR_CLOSE = 8'h10;
  localparam logic [7:0] ADR_MON = 8'h14;
  localparam logic [7:0] ADR_PCD = 8'h18;
  localparam logic [7:0] ADR_THR = 8'h1C;
  localparam logic [7:0] ADR_SFREQ = 8'h20;
  localparam logic [7:0] ADR_STORQ = 8'h24;
  localparam logic [7:0] ADR_STAT = 8'h28;

  // ====================================================
  // field positions
  localparam int CMD_ON = 0;
  localparam int CMD_RAMP = 1;
  localparam int CMD_QUICK = 2;
  localparam int CMD_COAST = 3;
  localparam int MD_BRK = 0;
  localparam int MD_FOS = 2;
  localparam int MD_FCS = 4;
  localparam int MD_SFS = 6;
  localparam int MD_STS = 8;
  localparam int MD_SWO = 10;
  localparam int MD_SWC = 11;
  localparam int ST_MOTOR = 0;
  localparam int ST_HOLD = 1;
  localparam int ST_SLIP = 2;
  localparam int ST_QUICK = 3;
  localparam int ST_STATE = 4;
  localparam int ST_BRAKE = 12;

  // ====================================================
  // types
  typedef enum logic [1:0] {
    HBS_BRK_LOCK = 2'h0,
    HBS_BRK_SEQ = 2'h1,
    HBS_BRK_OPEN = 2'h2,
    HBS_BRK_LINK = 2'h3
  } hbs_brk_type;

  typedef enum logic [2:0] {
    HBS_IDLE = 3'h0,
    HBS_MAG = 3'h1,
    HBS_OPEN = 3'h3,
    HBS_RUN = 3'h2,
    HBS_STOP = 3'h6,
    HBS_CLOSE = 3'h7
  } hbs_seq_type;

  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } hbs_av_req_type;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } hbs_av_rsp_type;

  typedef struct packed {
    hbs_seq_type st;
    logic [DIV_W-1:0] div;
    logic [TW-1:0] cnt_a;
    logic [TW-1:0] cnt_b;
    logic mon_run;
    logic pcd_run;
    logic quick;
    logic [11:0] mode;
    logic [TW-1:0] t_mag;
    logic [TW-1:0] t_open;
    logic [TW-1:0] t_close;
    logic [TW-1:0] t_mon;
    logic [TW-1:0] t_pcd;
    logic [SW-1:0] thr;
    logic [SW-1:0] sfreq;
    logic [SW-1:0] storq;
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic wt;
    logic [31:0] rdata;
    logic motor;
    logic brake;
    logic hold;
    logic slip;
    logic [SW-1:0] fout;
    logic [SW-1:0] tout;
  } hbs_state_type;

endpackage

// [src/hbs_brake_seq.sv]
/*
  hbs_brake_seq: holding brake sequencer with its Avalon-MM register
  slave, timers, mode and force selection.
  assumes speed inputs and external sources come from logic on mclk;
  the two force pins are asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// RULE_01 - on start, magnetize first, then open brake
// RULE_02 - hold zero speed until opening time ends
// RULE_03 - setpoint below threshold starts monitor timer
// RULE_04 - actual speed below threshold starts delay timer
// RULE_05 - first expiring stop timer closes brake
// RULE_06 - keep motor on for closing time
// RULE_07 - coast stop closes brake at once
// RULE_08 - brake mode: locked, sequence, open, linked
// RULE_09 - brake command readable as status bit 12
// RULE_10 - selectable forced open input, default none
// RULE_11 - selectable forced close input, default none
// RULE_12 - configurer keeps magnetizing time above zero
// RULE_13 - opening time exceeds relay plus release
// RULE_14 - closing time exceeds relay plus closing
// RULE_15 - nonzero start frequency enables slip compensation
// RULE_16 - start frequency from selectable source
// RULE_17 - start torque from selectable source
// RULE_18 - configurer raises boost or torque if sagging
// RULE_19 - timers count ticks, restart on requests
module hbs_brake_seq
  import hbs_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire hbs_av_req_type av_req,
  output var hbs_av_rsp_type av_rsp,
  input wire logic [SW-1:0] speed_setpoint,
  input wire logic [SW-1:0] speed_actual,
  input wire logic [SW-1:0] freq_ext,
  input wire logic [SW-1:0] torque_ext,
  input wire logic [1:0] force_pin,
  output logic motor_enable,
  output logic brake_open,
  output logic ramp_hold,
  output logic quick_ramp,
  output logic slip_comp_en,
  output logic [SW-1:0] startup_freq,
  output logic [SW-1:0] startup_torque
);

  localparam hbs_state_type RST_S = '{
    st: HBS_IDLE,
    wt: 1'b1,
    mode: RST_MODE,
    t_mag: RST_MAG,
    t_open: RST_OPEN,
    t_close: RST_CLOSE,
    t_mon: RST_MON,
    t_pcd: RST_PCD,
    thr: RST_THR,
    default: '0
  };

  hbs_state_type s_ff;
  hbs_state_type nxt_s;
  logic tick_c;
  logic accept_c;
  logic commit_c;
  logic on_c;
  logic stop_c;
  logic coast_c;
  logic done_c;
  logic fo_cur;
  logic fc_cur;

  // ====================================================
  // helpers
  function automatic logic [31:0] be_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] be
  );
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // source 0 is unconnected, 3 is the software bit
  function automatic logic src_bit(
    input logic [1:0] sel,
    input logic [1:0] pins,
    input logic sw
  );
    logic r;
    case (sel)
      2'h1: r = pins[0];
      2'h2: r = pins[1];
      2'h3: r = sw;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  function automatic logic [31:0] rd_mux(
    input hbs_state_type s,
    input logic [7:0] adr
  );
    logic [31:0] r;
    r = 32'h0;
    case (adr)
      ADR_MODE: r = {20'h0, s.mode};
      ADR_MAG: r = {12'h0, s.t_mag};
      ADR_OPEN: r = {12'h0, s.t_open};
      ADR_CLOSE: r = {12'h0, s.t_close};
      ADR_MON: r = {12'h0, s.t_mon};
      ADR_PCD: r = {12'h0, s.t_pcd};
      ADR_THR: r = {16'h0, s.thr};
      ADR_SFREQ: r = {16'h0, s.sfreq};
      ADR_STORQ: r = {16'h0, s.storq};
      ADR_STAT: begin
        r[ST_MOTOR] = s.motor;
        r[ST_HOLD] = s.hold;
        r[ST_SLIP] = s.slip;
        r[ST_QUICK] = s.quick;
        r[ST_STATE +: 3] = s.st;
        // RULE_09 brake status bit
        r[ST_BRAKE] = s.brake;
      end
      default: r = 32'h0;
    endcase
    return r;
  endfunction

  // ====================================================
  // bus decode
  // one wait cycle: accepted with waitrequest high, answered next
  assign accept_c = (av_req.read || av_req.write) && s_ff.wt;
  assign commit_c = av_req.write && !s_ff.wt;
  assign on_c = commit_c && av_req.address == ADR_CMD
    && av_req.byteenable[0] && av_req.writedata[CMD_ON];
  assign stop_c = commit_c && av_req.address == ADR_CMD
    && av_req.byteenable[0]
    && (av_req.writedata[CMD_RAMP] || av_req.writedata[CMD_QUICK]);
  assign coast_c = commit_c && av_req.address == ADR_CMD
    && av_req.byteenable[0] && av_req.writedata[CMD_COAST];
  assign tick_c = s_ff.div == DIV_W'(TICK_CYCLES - 1);
  // RULE_05 whichever timer expires first
  assign done_c = (s_ff.mon_run && s_ff.cnt_a >= s_ff.t_mon)
    || (s_ff.pcd_run && s_ff.cnt_b >= s_ff.t_pcd);
  assign fo_cur = src_bit(s_ff.mode[MD_FOS +: 2], s_ff.sync2,
    s_ff.mode[MD_SWO]);
  assign fc_cur = src_bit(s_ff.mode[MD_FCS +: 2], s_ff.sync2,
    s_ff.mode[MD_SWC]);

  // ====================================================
  // next state
  always_comb begin
    logic [31:0] wv;
    logic seq_brk;
    logic fo;
    logic fc;
    logic starting;
    wv = 32'h0;
    seq_brk = 1'b0;
    fo = 1'b0;
    fc = 1'b0;
    starting = 1'b0;
    nxt_s = s_ff;
    nxt_s.sync1 = force_pin;
    nxt_s.sync2 = s_ff.sync1;
    nxt_s.wt = !accept_c;
    if (accept_c && av_req.read) begin
      nxt_s.rdata = rd_mux(s_ff, av_req.address);
    end
    if (commit_c) begin
      wv = be_merge(rd_mux(s_ff, av_req.address), av_req.writedata,
        av_req.byteenable);
      case (av_req.address)
        ADR_MODE: nxt_s.mode = wv[11:0];
        ADR_MAG: nxt_s.t_mag = wv[TW-1:0];
        ADR_OPEN: nxt_s.t_open = wv[TW-1:0];
        ADR_CLOSE: nxt_s.t_close = wv[TW-1:0];
        ADR_MON: nxt_s.t_mon = wv[TW-1:0];
        ADR_PCD: nxt_s.t_pcd = wv[TW-1:0];
        ADR_THR: nxt_s.thr = wv[SW-1:0];
        ADR_SFREQ: nxt_s.sfreq = wv[SW-1:0];
        ADR_STORQ: nxt_s.storq = wv[SW-1:0];
        default: nxt_s.mode = s_ff.mode;
      endcase
    end
    // RULE_19 millisecond tick and saturating counters
    nxt_s.div = tick_c ? '0 : DIV_W'(s_ff.div + 1'b1);
    if (tick_c && !(&s_ff.cnt_a)) begin
      nxt_s.cnt_a = s_ff.cnt_a + 1'b1;
    end
    if (tick_c && s_ff.pcd_run && !(&s_ff.cnt_b)) begin
      nxt_s.cnt_b = s_ff.cnt_b + 1'b1;
    end
    case (s_ff.st)
      HBS_IDLE: begin
        if (on_c) begin
          nxt_s.st = HBS_MAG;
          nxt_s.cnt_a = '0;
          nxt_s.div = '0;
        end
      end
      // RULE_01 brake opens only after magnetizing
      HBS_MAG: begin
        if (s_ff.cnt_a >= s_ff.t_mag) begin
          nxt_s.st = HBS_OPEN;
          nxt_s.cnt_a = '0;
        end
      end
      // RULE_02 ramp released after opening time
      HBS_OPEN: begin
        if (s_ff.cnt_a >= s_ff.t_open) begin
          nxt_s.st = HBS_RUN;
        end
      end
      HBS_RUN: nxt_s.st = HBS_RUN;
      HBS_STOP: begin
        // RULE_03 monitor timer on setpoint
        if (!s_ff.mon_run && speed_setpoint < s_ff.thr) begin
          nxt_s.mon_run = 1'b1;
          nxt_s.cnt_a = '0;
        end
        // RULE_04 delay timer on measured speed
        if (!s_ff.pcd_run && speed_actual < s_ff.thr) begin
          nxt_s.pcd_run = 1'b1;
          nxt_s.cnt_b = '0;
        end
        // RULE_05 close on first expiry
        if (done_c) begin
          nxt_s.st = HBS_CLOSE;
          nxt_s.cnt_a = '0;
          nxt_s.mon_run = 1'b0;
          nxt_s.pcd_run = 1'b0;
        end
      end
      // RULE_06 motor stays energized while closing
      HBS_CLOSE: begin
        if (s_ff.cnt_a >= s_ff.t_close) begin
          nxt_s.st = HBS_IDLE;
        end
      end
      default: nxt_s.st = HBS_IDLE;
    endcase
    // RULE_19 stop request restarts the timers
    if (stop_c && (s_ff.st == HBS_MAG || s_ff.st == HBS_OPEN
        || s_ff.st == HBS_RUN)) begin
      nxt_s.st = HBS_STOP;
      nxt_s.cnt_a = '0;
      nxt_s.cnt_b = '0;
      nxt_s.div = '0;
      nxt_s.mon_run = 1'b0;
      nxt_s.pcd_run = 1'b0;
      nxt_s.quick = av_req.writedata[CMD_QUICK];
    end
    // RULE_07 coast stop drops motor, brake and hold at once
    if (coast_c) begin
      nxt_s.st = HBS_IDLE;
      nxt_s.mon_run = 1'b0;
      nxt_s.pcd_run = 1'b0;
    end
    // outputs follow the next state so they stay in step with it
    seq_brk = nxt_s.st == HBS_OPEN || nxt_s.st == HBS_RUN
      || nxt_s.st == HBS_STOP;
    starting = nxt_s.st == HBS_MAG || nxt_s.st == HBS_OPEN;
    // force sources read only the second sync stage, so the brake
    // follows a force change one cycle later than the sync output
    fo = fo_cur;
    fc = fc_cur;
    nxt_s.motor = nxt_s.st != HBS_IDLE;
    nxt_s.hold = starting;
    // RULE_08 brake mode selection
    case (hbs_brk_type'(nxt_s.mode[MD_BRK +: 2]))
      HBS_BRK_LOCK: nxt_s.brake = 1'b0;
      HBS_BRK_OPEN: nxt_s.brake = 1'b1;
      default: nxt_s.brake = seq_brk;
    endcase
    // RULE_10 forced open overrides the mode
    if (fo) begin
      nxt_s.brake = 1'b1;
    end
    // RULE_11 forced close wins over forced open
    if (fc || coast_c) begin
      nxt_s.brake = 1'b0;
    end
    // RULE_15 slip compensation follows start frequency
    nxt_s.slip = nxt_s.sfreq != '0;
    // RULE_16 start frequency source
    nxt_s.fout = '0;
    if (starting) begin
      case (nxt_s.mode[MD_SFS +: 2])
        2'h0: nxt_s.fout = nxt_s.sfreq;
        2'h1: nxt_s.fout = freq_ext;
        default: nxt_s.fout = '0;
      endcase
    end
    // RULE_17 start torque source
    nxt_s.tout = '0;
    if (starting) begin
      case (nxt_s.mode[MD_STS +: 2])
        2'h1: nxt_s.tout = nxt_s.storq;
        2'h2: nxt_s.tout = torque_ext;
        default: nxt_s.tout = '0;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      s_ff <= RST_S;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign av_rsp = '{readdata: s_ff.rdata, waitrequest: s_ff.wt};
  assign motor_enable = s_ff.motor;
  assign brake_open = s_ff.brake;
  assign ramp_hold = s_ff.hold;
  assign quick_ramp = s_ff.quick;
  assign slip_comp_en = s_ff.slip;
  assign startup_freq = s_ff.fout;
  assign startup_torque = s_ff.tout;

  // ====================================================
  // assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  mag_wait_a: assert property ( // RULE_01
    (s_ff.st == HBS_MAG ##1 s_ff.st == HBS_OPEN)
      |-> $past(s_ff.cnt_a) >= $past(s_ff.t_mag))
    else $error("brake opened before magnetizing ended");
  open_hold_a: assert property ( // RULE_02
    s_ff.st == HBS_OPEN |-> s_ff.hold && s_ff.motor)
    else $error("speed not held while brake opens");
  ramp_rel_a: assert property ( // RULE_02
    (s_ff.st == HBS_OPEN && s_ff.cnt_a >= s_ff.t_open
      && !coast_c && !stop_c) |=> s_ff.st == HBS_RUN && !s_ff.hold)
    else $error("ramp not released after opening time");
  mon_start_a: assert property ( // RULE_03
    (s_ff.st == HBS_STOP && !s_ff.mon_run && !done_c && !coast_c
      && speed_setpoint < s_ff.thr) |=> s_ff.mon_run)
    else $error("monitor timer did not start");
  pcd_start_a: assert property ( // RULE_04
    (s_ff.st == HBS_STOP && !s_ff.pcd_run && !done_c && !coast_c
      && speed_actual < s_ff.thr) |=> s_ff.pcd_run && s_ff.cnt_b == '0)
    else $error("delay timer did not start");
  first_close_a: assert property ( // RULE_05
    (s_ff.st == HBS_STOP && done_c && !coast_c)
      |=> s_ff.st == HBS_CLOSE)
    else $error("brake close not commanded on expiry");
  close_time_a: assert property ( // RULE_06
    (s_ff.st == HBS_CLOSE && s_ff.cnt_a >= s_ff.t_close)
      |=> !s_ff.motor)
    else $error("motor not disabled after closing time");
  close_energ_a: assert property ( // RULE_06
    s_ff.st == HBS_CLOSE |-> s_ff.motor)
    else $error("motor off during closing time");
  coast_stop_a: assert property ( // RULE_07
    coast_c |=> !s_ff.brake && !s_ff.motor)
    else $error("coast stop left brake open");
  mode_lock_a: assert property ( // RULE_08
    (s_ff.mode[MD_BRK +: 2] == 2'h0 && !$past(fo_cur)) |-> !s_ff.brake)
    else $error("locked mode opened the brake");
  status_bit_a: assert property ( // RULE_09
    (av_req.read && !s_ff.wt && av_req.address == ADR_STAT)
      |-> s_ff.rdata[ST_BRAKE] == $past(s_ff.brake))
    else $error("status bit 12 differs from brake command");
  force_open_a: assert property ( // RULE_10
    (fo_cur && !fc_cur) |=> s_ff.brake || $past(coast_c))
    else $error("forced open ignored");
  force_close_a: assert property ( // RULE_11
    fc_cur |=> !s_ff.brake)
    else $error("forced close ignored");
  slip_en_a: assert property ( // RULE_15
    $changed(s_ff.sfreq) |=> s_ff.slip == ($past(s_ff.sfreq) != '0))
    else $error("slip compensation wrong");
  freq_src_a: assert property ( // RULE_16
    (s_ff.hold && s_ff.mode[MD_SFS +: 2] == 2'h0)
      |-> s_ff.fout == s_ff.sfreq)
    else $error("start frequency not from its setting");
  torque_src_a: assert property ( // RULE_17
    (s_ff.hold && s_ff.mode[MD_STS +: 2] == 2'h0) |-> s_ff.tout == '0)
    else $error("default torque source not zero");
  restart_a: assert property ( // RULE_19
    (on_c && s_ff.st == HBS_IDLE && !coast_c)
      |=> s_ff.st == HBS_MAG && s_ff.cnt_a == '0 && s_ff.div == '0)
    else $error("timers not restarted on switch-on");

  full_cycle_c: cover property (
    s_ff.st == HBS_CLOSE ##1 s_ff.st == HBS_IDLE);
  coast_run_c: cover property (s_ff.st == HBS_RUN && coast_c);
  pcd_first_c: cover property (
    s_ff.st == HBS_STOP && s_ff.pcd_run && s_ff.cnt_b >= s_ff.t_pcd);
  forced_c: cover property (fo_cur && s_ff.st == HBS_IDLE);

endmodule

`default_nettype wire

// [tb/hbs_brake_model.sv]
/*
  hbs_brake_model: holding brake with its signal relay, the far side
  of the sequencer. it lifts and drops the brake after fixed delays.
  assumes the brake command and motor signals are levels on mclk.
*/
`timescale 1ns/1ps
`default_nettype none

module hbs_brake_model #(
  parameter int RELAY_CYC = 5,
  parameter int LIFT_CYC = 12,
  parameter int DROP_CYC = 8
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic brake_cmd,
  input wire logic motor_on,
  input wire logic ramp_hold,
  output logic released,
  output logic accel_err,
  output logic sag_err
);
  int cnt;
  logic cmd_d;
  logic mot_d;

  // ==================================================
  // relay and shoe
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      cnt <= 0;
      cmd_d <= 1'b0;
      mot_d <= 1'b0;
      released <= 1'b0;
      accel_err <= 1'b0;
      sag_err <= 1'b0;
    end else begin
      cmd_d <= brake_cmd;
      mot_d <= motor_on;
      cnt <= (brake_cmd != cmd_d) ? 0 : cnt + 1;
      if (brake_cmd && cnt >= RELAY_CYC + LIFT_CYC)
        released <= 1'b1;
      if (!brake_cmd && cnt >= RELAY_CYC + DROP_CYC)
        released <= 1'b0;
      if (motor_on && !ramp_hold && brake_cmd && !released)
        accel_err <= 1'b1;
      if (mot_d && !motor_on && released)
        sag_err <= 1'b1;
    end
  end
endmodule

`default_nettype wire

// [tb/tb_top.sv]
/*
  tb_top: self-checking bench for the holding brake sequencer.
  assumes hbs_pkg and the brake model are compiled first; the ms
  tick is shortened to 10 clocks so all timers run quickly.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import hbs_pkg::*;
  localparam int T = 10;
  logic mclk, rst_b;
  hbs_av_req_type av_req;
  hbs_av_rsp_type av_rsp;
  logic [SW-1:0] sp, sa, fx, tx, sfreq, storq;
  logic [1:0] fpin;
  logic motor_enable, brake_open, ramp_hold, quick_ramp, slip_comp_en;
  logic released, accel_err, sag_err;
  logic [2:0] outs;
  logic [31:0] rd;
  int n_mismatch, n_checks;

  assign outs = {ramp_hold, brake_open, motor_enable};

  hbs_brake_seq #(.TICK_CYCLES(T)) dut (.mclk(mclk), .rst_b(rst_b),
    .av_req(av_req), .av_rsp(av_rsp), .speed_setpoint(sp),
    .speed_actual(sa), .freq_ext(fx), .torque_ext(tx),
    .force_pin(fpin), .motor_enable(motor_enable),
    .brake_open(brake_open), .ramp_hold(ramp_hold),
    .quick_ramp(quick_ramp), .slip_comp_en(slip_comp_en),
    .startup_freq(sfreq), .startup_torque(storq));

  hbs_brake_model brk (.mclk(mclk), .rst_b(rst_b),
    .brake_cmd(brake_open), .motor_on(motor_enable),
    .ramp_hold(ramp_hold), .released(released),
    .accel_err(accel_err), .sag_err(sag_err));

  // ==================================================
  // checking and closing
  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ==================================================
  // bus access: one request held until waitrequest sampled low
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    i = 0;
    @(posedge mclk);
    av_req <= '{~wr, wr, a, d, 4'hF};
    do begin
      @(posedge mclk);
      i++;
    end while (av_rsp.waitrequest !== 1'b0 && i < 40);
    rd = av_rsp.readdata;
    av_req <= '{1'b0, 1'b0, 8'h00, 32'h0, 4'h0};
    if (av_rsp.waitrequest !== 1'b0) begin
      chk("bus answer", 32'h0, 32'h1);
      finish_test();
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp,
                      input string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, exp, rd);
  endtask

  // edges until outs[idx] reaches v; must land within lo..hi
  task automatic wsig(input int idx, input logic v, input int lo,
                      input int hi, input string nm);
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (outs[idx] !== v && n <= hi);
    n_checks++;
    if (outs[idx] !== v || n < lo || n > hi) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", nm, lo, hi,
               n);
      if (outs[idx] !== v)
        finish_test();
    end
  endtask

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // a hang anywhere ends here
  initial begin
    repeat (100000) @(posedge mclk);
    chk("run length", 32'h0, 32'h1);
    finish_test();
  end

  // ==================================================
  // main sequence
  initial begin
    n_mismatch = 0;
    n_checks = 0;
    rst_b = 1'b0;
    av_req = '0;
    sp = 16'h0064;
    sa = 16'h0064;
    fx = 16'h0AAA;
    tx = 16'h0BBB;
    fpin = 2'h0;
    repeat (6) @(posedge mclk);
    #1;
    chk("wait in reset", 32'h1, av_rsp.waitrequest);
    chk("outputs in reset", 32'h0, outs);
    @(posedge mclk);
    rst_b <= 1'b1;
    rchk(ADR_MODE, 32'h0, "mode reset");
    rchk(ADR_MAG, 32'h0, "magnetize reset");
    rchk(ADR_OPEN, 32'h64, "open reset");
    rchk(ADR_CLOSE, 32'h64, "close reset");
    rchk(ADR_MON, 32'h493E0, "monitor reset");
    rchk(ADR_PCD, 32'hA, "delay reset");
    rchk(ADR_THR, 32'h14, "threshold reset");
    rchk(ADR_SFREQ, 32'h0, "start freq reset");
    rchk(ADR_STORQ, 32'h0, "start torque reset");
    bus(1'b1, ADR_STAT, 32'hFFFFFFFF);
    rchk(ADR_STAT, 32'h0, "status read only");
    rchk(8'h30, 32'h0, "unmapped read");
    rchk(ADR_CMD, 32'h0, "command reads zero");
    bus(1'b1, ADR_MAG, 32'h2);
    bus(1'b1, ADR_OPEN, 32'h3);
    bus(1'b1, ADR_CLOSE, 32'h3);
    bus(1'b1, ADR_MON, 32'h4);
    bus(1'b1, ADR_PCD, 32'h2);
    bus(1'b1, ADR_SFREQ, 32'h0123);
    bus(1'b1, ADR_STORQ, 32'h0456);
    @(posedge mclk);
    #1;
    chk("slip on", 32'h1, slip_comp_en);
    // forcing in idle, brake mode locked
    bus(1'b1, ADR_MODE, 32'h40C);
    wsig(1, 1'b1, 1, 4, "force open sw");
    rchk(ADR_STAT, 32'h1004, "status forced");
    bus(1'b1, ADR_MODE, 32'h24);
    @(posedge mclk);
    fpin <= 2'b01;
    wsig(1, 1'b1, 1, 6, "force open pin");
    @(posedge mclk);
    fpin <= 2'b11;
    wsig(1, 1'b0, 1, 6, "force close pin");
    // second pin as open source, software bit as close source
    bus(1'b1, ADR_MODE, 32'h8);
    wsig(1, 1'b1, 1, 4, "force open pin1");
    bus(1'b1, ADR_MODE, 32'h838);
    wsig(1, 1'b0, 1, 4, "force close sw");
    bus(1'b1, ADR_MODE, 32'h4);
    wsig(1, 1'b1, 1, 4, "close source off");
    bus(1'b1, ADR_MODE, 32'h0);
    wsig(1, 1'b0, 1, 4, "open source off");
    @(posedge mclk);
    fpin <= 2'b00;
    // sequenced start and ramp stop
    bus(1'b1, ADR_MODE, 32'h101);
    bus(1'b1, ADR_CMD, 32'h1);
    wsig(0, 1'b1, 1, 1, "motor on");
    chk("brake during magnetize", 32'h0, brake_open);
    chk("hold at start", 32'h1, ramp_hold);
    repeat (5) @(posedge mclk);
    #1;
    chk("start freq reg", 32'h0123, sfreq);
    chk("start torque reg", 32'h0456, storq);
    wsig(1, 1'b1, 2*T-8, 3*T+3, "magnetize wait");
    chk("hold while opening", 32'h1, ramp_hold);
    wsig(2, 1'b0, 3*T-2, 4*T+3, "opening time");
    chk("start freq gone", 32'h0, sfreq);
    bus(1'b1, ADR_CMD, 32'h2);
    @(posedge mclk);
    sp <= 16'h0005;
    wsig(1, 1'b0, 4*T-2, 5*T+4, "monitor expiry");
    chk("motor after close", 32'h1, motor_enable);
    wsig(0, 1'b0, 3*T-2, 4*T+3, "closing time");
    chk("ramp stop kind", 32'h0, quick_ramp);
    // quick stop: speeds at threshold must not count as standstill
    @(posedge mclk);
    sp <= 16'h0064;
    bus(1'b1, ADR_CMD, 32'h1);
    wsig(2, 1'b0, 5*T-2, 7*T+4, "restart timing");
    bus(1'b1, ADR_CMD, 32'h4);
    @(posedge mclk);
    sp <= 16'h0014;
    sa <= 16'h0014;
    repeat (8*T) @(posedge mclk);
    #1;
    chk("threshold strict", 32'h1, brake_open);
    @(posedge mclk);
    sa <= 16'h0013;
    wsig(1, 1'b0, 2*T-2, 3*T+3, "delay expiry");
    chk("quick stop kind", 32'h1, quick_ramp);
    wsig(0, 1'b0, 3*T-2, 4*T+3, "quick closing");
    chk("load held", 32'h0, sag_err);
    @(posedge mclk);
    sp <= 16'h0064;
    sa <= 16'h0064;
    // every brake mode and source choice, ended by a coast stop
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, ADR_MODE, {22'h0, 2'(k), 2'(k), 4'h0, 2'(k)});
      bus(1'b1, ADR_CMD, 32'h1);
      repeat (5) @(posedge mclk);
      #1;
      chk("freq source", (k == 0) ? 32'h0123 : (k == 1) ? 32'(fx) : 32'h0,
          sfreq);
      chk("torque source", (k == 1) ? 32'h0456 : (k == 2) ? 32'(tx) :
          32'h0, storq);
      wsig(2, 1'b0, 5*T-8, 7*T+4, "mode run");
      chk("brake by mode", (k != 0), brake_open);
      rchk(ADR_STAT, {19'h0, (k != 0), 12'h02D}, "status brake");
      bus(1'b1, ADR_CMD, 32'h8);
      wsig(0, 1'b0, 1, 1, "coast motor");
      // mode 2 reopens the brake once the coast commit cycle is over
      chk("coast brake", 32'(k == 2), brake_open);
    end
    bus(1'b1, ADR_SFREQ, 32'h0);
    @(posedge mclk);
    #1;
    chk("slip off", 32'h0, slip_comp_en);
    chk("no pull on brake", 32'h0, accel_err);
    finish_test();
  end
endmodule

`default_nettype wire
